// ==== design/fec_codec.v ====
// Function
// - Transmit uses the 4B/5B code in both copper and fiber modes and receive decodes it back.
// - Each data nibble maps to its fixed 5-bit group and back, 0000 to 11110 through 1111 to 11101.
// - Group 11111 is sent as idle, 00100 as transmit error, and both decode as control.
// - Frame start is 11000 then 10001, each decoding to nibble 0101.
// - Frame end is 01101 then 00111, neither being a data nibble.
`timescale 1ns/1ps
`include "fec_consts.vh"
module fec_codec #(
  parameter DEPTH = `FEC_FIFO_DEPTH,
  parameter AW    = `FEC_FIFO_AW
) (
  input  wire       clk,
  input  wire       reset,
  input  wire       fiber_mode,
  input  wire [3:0] tx_nibble,
  input  wire       tx_en,
  input  wire       tx_er,
  output wire       tx_ready,
  output reg  [4:0] tx_group_r,
  input  wire       tx_group_take,
  input  wire [4:0] rx_group,
  input  wire       rx_group_valid,
  output reg  [3:0] rx_nibble_r,
  output reg        rx_data_r,
  output reg        rx_idle_r,
  output reg        rx_ssd_r,
  output reg        rx_esd_r,
  output reg        rx_txerr_r,
  output reg        rx_invalid_r,
  output reg        rx_valid_r,
  output reg        tx_mode_fiber_r
);
  // fiber and copper share one code; mode is only reported
  function [4:0] enc;
    input [3:0] n;
    begin
      case (n)
        4'h0: enc = 5'h1E;
        4'h1: enc = 5'h09;
        4'h2: enc = 5'h14;
        4'h3: enc = 5'h15;
        4'h4: enc = 5'h0A;
        4'h5: enc = 5'h0B;
        4'h6: enc = 5'h0E;
        4'h7: enc = 5'h0F;
        4'h8: enc = 5'h12;
        4'h9: enc = 5'h13;
        4'hA: enc = 5'h16;
        4'hB: enc = 5'h17;
        4'hC: enc = 5'h1A;
        4'hD: enc = 5'h1B;
        4'hE: enc = 5'h1C;
        default: enc = 5'h1D;
      endcase
    end
  endfunction

  // start groups both stand for the preamble nibble
  function is_ssd;
    input [4:0] g;
    begin
      is_ssd = (g == `FEC_GRP_SSD1) | (g == `FEC_GRP_SSD2);
    end
  endfunction

  function is_esd;
    input [4:0] g;
    begin
      is_esd = (g == `FEC_GRP_ESD1) | (g == `FEC_GRP_ESD2);
    end
  endfunction

  localparam ST_IDLE = 3'h0;
  localparam ST_SSD2 = 3'h1;
  localparam ST_DATA = 3'h2;
  localparam ST_ESD2 = 3'h4;

  // fifo word: {tx_er, nibble}; only pushed words exist, so no enable bit
  wire [4:0] fq_data;
  wire       fq_valid;
  reg        fq_ready;
  fec_fifo #(
    .W  (5),
    .D  (DEPTH),
    .AW (AW)
  ) fec_fifo_i (
    .clk       (clk),
    .reset     (reset),
    .in_data   ({tx_er, tx_nibble}),
    .in_valid  (tx_en),
    .in_ready  (tx_ready),
    .out_data  (fq_data),
    .out_valid (fq_valid),
    .out_ready (fq_ready)
  );

  reg [2:0] st_r;
  reg [2:0] st_nxt;
  reg [4:0] grp_nxt;

  always @*
  begin
    st_nxt   = st_r;
    grp_nxt  = tx_group_r;
    fq_ready = 1'h0;
    if (tx_group_take)
    begin
      case (st_r)
        ST_IDLE:
        begin
          // start on the first nibble; the two start groups give slack
          if (fq_valid)
          begin
            grp_nxt = `FEC_GRP_SSD1;
            st_nxt  = ST_SSD2;
          end
          else
            grp_nxt = `FEC_GRP_IDLE;
        end
        ST_SSD2:
        begin
          grp_nxt = `FEC_GRP_SSD2;
          st_nxt  = ST_DATA;
        end
        ST_DATA:
        begin
          if (fq_valid)
          begin
            fq_ready = 1'h1;
            grp_nxt  = fq_data[4] ? `FEC_GRP_TXER
                                  : enc(fq_data[3:0]);
          end
          else
          begin
            // underrun ends the frame: no room for gaps in a stream
            grp_nxt = `FEC_GRP_ESD1;
            st_nxt  = ST_ESD2;
          end
        end
        ST_ESD2:
        begin
          grp_nxt = `FEC_GRP_ESD2;
          st_nxt  = ST_IDLE;
        end
        default:
        begin
          grp_nxt = `FEC_GRP_IDLE;
          st_nxt  = ST_IDLE;
        end
      endcase
    end
  end

  always @(posedge clk)
  begin
    if (reset)
    begin
      st_r            <= ST_IDLE;
      tx_group_r      <= `FEC_GRP_IDLE;
      tx_mode_fiber_r <= 1'h0;
    end
    else
    begin
      st_r            <= st_nxt;
      tx_group_r      <= grp_nxt;
      tx_mode_fiber_r <= fiber_mode;
    end
  end

  reg [3:0] dn;
  reg       dd;
  integer   i;
  always @*
  begin
    dn = 4'h0;
    dd = 1'h0;
    for (i = 0; i < 16; i = i + 1)
      if (enc(i[3:0]) == rx_group)
      begin
        dn = i[3:0];
        dd = 1'h1;
      end
  end

  always @(posedge clk)
  begin
    if (reset)
    begin
      rx_nibble_r  <= 4'h0;
      rx_data_r    <= 1'h0;
      rx_idle_r    <= 1'h0;
      rx_ssd_r     <= 1'h0;
      rx_esd_r     <= 1'h0;
      rx_txerr_r   <= 1'h0;
      rx_invalid_r <= 1'h0;
      rx_valid_r   <= 1'h0;
    end
    else
    begin
      rx_valid_r   <= rx_group_valid;
      rx_data_r    <= rx_group_valid & dd;
      rx_idle_r    <= rx_group_valid & (rx_group == `FEC_GRP_IDLE);
      rx_txerr_r   <= rx_group_valid & (rx_group == `FEC_GRP_TXER);
      rx_ssd_r     <= rx_group_valid & is_ssd(rx_group);
      rx_esd_r     <= rx_group_valid & is_esd(rx_group);
      // a group that neither the data table nor a control code claims
      rx_invalid_r <= rx_group_valid & ~dd &
                      (rx_group != `FEC_GRP_IDLE) &
                      (rx_group != `FEC_GRP_TXER) &
                      ~is_ssd(rx_group) & ~is_esd(rx_group);
      if (rx_group_valid)
      begin
        if (dd)
          rx_nibble_r <= dn;
        else if (is_ssd(rx_group))
          rx_nibble_r <= `FEC_NIB_SSD;
        else
          rx_nibble_r <= 4'h0;
      end
    end
  end
endmodule

// ==== design/fec_consts.vh ====
`ifndef FEC_CONSTS_VH
`define FEC_CONSTS_VH
`define FEC_GRP_IDLE  5'h1F
`define FEC_GRP_SSD1  5'h18
`define FEC_GRP_SSD2  5'h11
`define FEC_GRP_ESD1  5'h0D
`define FEC_GRP_ESD2  5'h07
`define FEC_GRP_TXER  5'h04
`define FEC_NIB_SSD   4'h5
`define FEC_FIFO_DEPTH 16
`define FEC_FIFO_AW    4
`endif

// ==== design/fec_fifo.v ====
`timescale 1ns/1ps
module fec_fifo #(
  parameter W  = 6,
  parameter D  = 16,
  parameter AW = 4
) (
  input  wire         clk,
  input  wire         reset,
  input  wire [W-1:0] in_data,
  input  wire         in_valid,
  output wire         in_ready,
  output wire [W-1:0] out_data,
  output wire         out_valid,
  input  wire         out_ready
);
  reg [W-1:0] mem_r [0:D-1];
  reg [AW-1:0] wp_r;
  reg [AW-1:0] rp_r;
  reg [AW:0]   cnt_r;
  wire         wr;
  wire         rd;
  assign in_ready  = (cnt_r != D);
  assign out_valid = (cnt_r != 0);
  assign out_data  = mem_r[rp_r];
  assign wr = in_valid & in_ready;
  assign rd = out_valid & out_ready;
  always @(posedge clk)
  begin
    if (reset)
    begin
      wp_r  <= {AW{1'h0}};
      rp_r  <= {AW{1'h0}};
      cnt_r <= {(AW+1){1'h0}};
    end
    else
    begin
      if (wr)
      begin
        mem_r[wp_r] <= in_data;
        wp_r        <= (wp_r == D-1) ? {AW{1'h0}} : wp_r + 1'h1;
      end
      if (rd)
        rp_r <= (rp_r == D-1) ? {AW{1'h0}} : rp_r + 1'h1;
      if (wr & ~rd)
        cnt_r <= cnt_r + 1'h1;
      else if (rd & ~wr)
        cnt_r <= cnt_r - 1'h1;
    end
  end
endmodule

// ==== sim/fec_line_model.sv ====
`timescale 1ns/1ps
module fec_line_model (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic stall,
  output logic      take
);
  // registered, so a stall reaches the codec one edge late
  always @(posedge clk)
    take <= !reset && !stall;
endmodule

// ==== sim/fec_codec_sva.sv ====
`timescale 1ns/1ps
module fec_codec_sva (
  input wire logic       clk,
  input wire logic       reset,
  input wire logic [4:0] rx_group,
  input wire logic       rx_group_valid,
  input wire logic       rx_data_r,
  input wire logic       rx_idle_r,
  input wire logic       rx_esd_r,
  input wire logic       rx_invalid_r,
  input wire logic       rx_valid_r,
  input wire logic [4:0] tx_group_r,
  input wire logic       tx_group_take
);
  wire v = rx_group_valid;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  property p_val;
    v |=> rx_valid_r;
  endproperty
  a_val: assert property (p_val) else $error("no valid");
  property p_dat;
    v && rx_group == 5'h1E |=> rx_data_r && !rx_invalid_r;
  endproperty
  a_dat: assert property (p_dat) else $error("data");
  property p_idl;
    v && rx_group == 5'h1F |=> rx_idle_r && !rx_data_r;
  endproperty
  a_idl: assert property (p_idl) else $error("idle");
  property p_tsd;
    tx_group_r == 5'h18 && tx_group_take |=> tx_group_r == 5'h11;
  endproperty
  a_tsd: assert property (p_tsd) else $error("start");
  property p_esd;
    v && rx_group == 5'h0D |=> rx_esd_r && !rx_data_r;
  endproperty
  a_esd: assert property (p_esd) else $error("end");
  property p_inv;
    v && rx_group == 5'h00 |=> rx_invalid_r;
  endproperty
  a_inv: assert property (p_inv) else $error("invalid");
endmodule
bind fec_codec fec_codec_sva fec_codec_sva_i (.clk(clk), .reset(reset),
  .rx_group(rx_group), .rx_group_valid(rx_group_valid),
  .rx_data_r(rx_data_r), .rx_idle_r(rx_idle_r), .rx_esd_r(rx_esd_r),
  .rx_invalid_r(rx_invalid_r), .rx_valid_r(rx_valid_r),
  .tx_group_r(tx_group_r), .tx_group_take(tx_group_take));

// ==== sim/fec_codec_test.sv ====
`timescale 1ns/1ps
module fec_codec_test;
  logic        clk = 0, reset = 1, fiber_mode = 0, tx_en = 0, tx_er = 0;
  logic        rx_group_valid = 0, stall = 1, take, tx_ready;
  logic        d, i, s, e, t, n, v, fib;
  logic [3:0]  tx_nibble = 0, rx_nibble_r;
  logic [4:0]  rx_group = 0, tx_group_r;
  logic [10:0] x;
  int          n_fail = 0, n_compared = 0, cyc = 0;
  logic [4:0]  enc [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E,
    5'h0F, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
  // rows: {group, nibble, data idle start end err invalid valid}
  logic [15:0] rows [32] = '{
    16'h0003, 16'h0803, 16'h1003, 16'h1803, 16'h2005, 16'h2803, 16'h3003,
    16'h3809, 16'h4003, 16'h48C1, 16'h5241, 16'h5AC1, 16'h6003, 16'h6809,
    16'h7341, 16'h7BC1, 16'h8003, 16'h8A91, 16'h9441, 16'h9CC1, 16'hA141,
    16'hA9C1, 16'hB541, 16'hBDC1, 16'hC291, 16'hC803, 16'hD641, 16'hDEC1,
    16'hE741, 16'hEFC1, 16'hF041, 16'hF821};
  logic [10:0] rx_word;
  always #12.5 clk = !clk;
  fec_codec fec_codec_i (.clk(clk), .reset(reset), .fiber_mode(fiber_mode),
    .tx_nibble(tx_nibble), .tx_en(tx_en), .tx_er(tx_er), .tx_ready(tx_ready),
    .tx_group_r(tx_group_r), .tx_group_take(take), .rx_group(rx_group),
    .rx_group_valid(rx_group_valid), .rx_nibble_r(rx_nibble_r),
    .rx_data_r(d), .rx_idle_r(i), .rx_ssd_r(s), .rx_esd_r(e),
    .rx_txerr_r(t), .rx_invalid_r(n), .rx_valid_r(v), .tx_mode_fiber_r(fib));
  fec_line_model fec_line_model_i (.clk(clk), .reset(reset), .stall(stall),
    .take(take));
  assign rx_word = {rx_nibble_r, d, i, s, e, t, n, v};
  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      n_fail++;
      end_of_test;
    end
  end
  initial
  begin
    repeat (5) @(posedge clk);
    reset <= 0;
    @(posedge clk);
    #1 chk({tx_ready, v, tx_group_r}, {2'h2, 5'h1F});
    $display("power-up reset done");
    for (int r = 0; r < 32; r++)
    begin
      @(posedge clk);
      rx_group       <= rows[r][15:11];
      rx_group_valid <= 1'h1;
      @(posedge clk);
      #1 chk(rx_word, rows[r][10:0]);
    end
    // valid low: no flags, nibble holds
    @(posedge clk);
    rx_group_valid <= 1'h0;
    @(posedge clk);
    #1 chk(rx_word, 11'h000);
    $display("rx table done");
    // line stalled while a 17th nibble hits the full buffer
    for (int m = 0; m < 2; m++)
    begin
      @(posedge clk);
      stall      <= 1'h1;
      fiber_mode <= m[0];
      for (int k = 0; k < 17; k++)
      begin
        @(posedge clk);
        tx_en <= 1;
        tx_nibble <= k[3:0];
        tx_er <= k == 3;
      end
      @(posedge clk);
      tx_en <= 0;
      stall <= 0;
      #1 chk({tx_ready, fib}, {1'h0, m[0]});
      for (int w = 0; w < 9 && tx_group_r !== 5'h18; w++)
        @(posedge clk) #1;
      for (int k = 0; k < 21; k++)
      begin
        x = k == 0 ? 5'h18 : k == 1 ? 5'h11 : k == 5 ? 5'h04 : k < 18 ?
          enc[k-2] : k == 18 ? 5'h0D : k == 19 ? 5'h07 : 5'h1F;
        chk(tx_group_r, x);
        @(posedge clk) #1;
      end
      $display("tx frame done");
    end
    // reset in mid-frame: line back to idle, buffer and flags cleared
    @(posedge clk);
    tx_en          <= 1'h1;
    tx_nibble      <= 4'h9;
    rx_group       <= 5'h13;
    rx_group_valid <= 1'h1;
    repeat (4) @(posedge clk);
    reset          <= 1'h1;
    tx_en          <= 1'h0;
    rx_group_valid <= 1'h0;
    #1 chk({d, v, rx_nibble_r, tx_group_r}, {2'h3, 4'h9, 5'h13});
    repeat (2) @(posedge clk);
    reset <= 1'h0;
    @(posedge clk);
    #1 chk({tx_ready, d, v, rx_nibble_r}, {3'h4, 4'h0});
    chk(tx_group_r, 5'h1F);
    @(posedge clk);
    #1 chk({tx_ready, v, tx_group_r}, {2'h2, 5'h1F});
    $display("reset test done");
    end_of_test;
  end
endmodule
